// [include/csl_regs.svh]
/*
 Timing and framing constants for the configuration serial loader and readback block.
 Assumes inclusion by bare name from the package file; the design files rely on it and do not include it.
*/
`ifndef CSL_REGS_SVH
`define CSL_REGS_SVH
`define CSL_MODE_SLAVE_SERIAL   3'h7
`define CSL_MODE_SYNC_PERIPH    3'h3
`define CSL_RB_DUMMY_BITS       5
`define CSL_RB_FORCED_FIRST     2
`define CSL_RB_CHECK_BITS       4
`define CSL_RB_LAST_HIGH_BITS   7
`define CSL_RB_SIG_BITS         11
`define CSL_CRC_POLY            16'h1021
`define CSL_CRC_INIT            16'h0000
`define CSL_BYTE_PERIOD         8
`define CSL_FIRST_BYTE_EDGE     2
`endif

// [include/csl_pkg.sv]
/*
 Types shared by the configuration serial loader and readback block.
 Assumes csl_regs.svh is on the include path.
*/
`include "csl_regs.svh"
package csl_pkg;
	typedef enum logic [5:0] {
		CSL_RB_IDLE  = 6'h01,
		CSL_RB_DUMMY = 6'h02,
		CSL_RB_START = 6'h04,
		CSL_RB_DATA  = 6'h08,
		CSL_RB_CHECK = 6'h10,
		CSL_RB_SIG   = 6'h20
	} csl_rb_state_t;
endpackage

// [hdl/csl_sync.sv]
/*
 Two flip-flop synchroniser with rising and falling edge detection after the second stage.
 Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ns
module csl_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] meta_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_q <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
		end else begin
			meta_q <= async_in;
			s2_q   <= meta_q;
			s3_q   <= s2_q;
		end
	end
	// Edges come from the second and third stages only, never the metastable one.
	assign sync_out = s2_q;
	assign rise     = s2_q & ~s3_q;
	assign fall     = ~s2_q & s3_q;
endmodule

// [hdl/csl_skid.sv]
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes both sides run on clk.
*/
`timescale 1ns/1ns
module csl_skid #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	logic [W-1:0] mem_q [2];
	logic         wp_q;
	logic         rp_q;
	logic [1:0]   cnt_q;
	wire          push = in_valid & in_ready;
	wire          pop  = out_valid & out_ready;
	assign in_ready  = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = mem_q[rp_q];
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) begin
				mem_q[wp_q] <= in_data;
				wp_q        <= ~wp_q;
			end
			if (pop)
				rp_q <= ~rp_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// [hdl/csl_config_port.sv]
/*
 Configuration serial port: slave serial and synchronous peripheral loading with
 daisy-chain forwarding, and a readback shifter on the readback shift clock.
 Assumes configuration_clock and readback_shift_clock are slow pins sampled by clk,
 and that the configuration memory is read through a one-bit read port addressed by rb_addr.
*/
`timescale 1ns/1ns
module csl_config_port
	import csl_pkg::*;
#(
	parameter int CFG_BITS    = 64,
	parameter int FRAME_BITS  = 16,
	parameter int FRAMES      = 4,
	parameter int AW          = 8
) (
	input  wire logic          clk,
	input  wire logic          sys_rst,
	input  wire logic [2:0]    mode_select_pins,
	input  wire logic          mem_clear_done,
	input  wire logic          configuration_clock,
	input  wire logic          config_serial_in,
	input  wire logic [7:0]    parallel_config_byte,
	output logic               daisy_serial_out,
	output logic               byte_ack,
	output logic               load_bit_valid,
	input  wire logic          load_bit_ready,
	output logic               load_bit_data,
	input  wire logic          config_done,
	input  wire logic          capture_state_en,
	input  wire logic          readback_trigger,
	input  wire logic          readback_shift_clock,
	output logic [AW-1:0]      rb_addr,
	input  wire logic          rb_cfg_bit,
	input  wire logic          rb_state_bit,
	input  wire logic          rb_state_valid,
	output logic               readback_serial_out,
	output logic               read_in_progress_flag
);
	localparam int CW = $clog2(CFG_BITS + 1);
	localparam int FW = $clog2(FRAME_BITS + 1);

	// Pin synchronisers: clocks and data from outside the clk domain.
	logic [12:0] pin_sync;
	logic [12:0] pin_rise;
	logic [12:0] pin_fall;
	csl_sync #(.W(13)) u_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in ({readback_trigger, readback_shift_clock, configuration_clock,
			config_serial_in, mem_clear_done, parallel_config_byte}),
		.sync_out (pin_sync),
		.rise     (pin_rise),
		.fall     (pin_fall)
	);
	wire       trig_s   = pin_sync[12];
	wire       rclk_up  = pin_rise[11];
	wire       configuration_clock_up  = pin_rise[10];
	wire       configuration_clock_dn  = pin_fall[10];
	wire       din_s    = pin_sync[9];
	wire       clr_s    = pin_sync[8];
	wire [7:0] byte_s   = pin_sync[7:0];

	// Mode pins are static during configuration; sample them once per clk.
	logic [2:0] mode_q;
	logic [2:0] mode_m_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_m_q <= `CSL_MODE_SLAVE_SERIAL;
			mode_q   <= `CSL_MODE_SLAVE_SERIAL;
		end else begin
			mode_m_q <= mode_select_pins;
			mode_q   <= mode_m_q;
		end
	end
	wire is_serial = (mode_q == `CSL_MODE_SLAVE_SERIAL);
	wire is_periph = (mode_q == `CSL_MODE_SYNC_PERIPH);

	// Loading: count rising edges since the memory-clear line went high.
	logic [CW-1:0] ld_cnt_q;
	logic [CW-1:0] ld_cnt_d;
	logic [2:0]    ph_q;
	logic [2:0]    ph_d;
	logic          started_q;
	logic [7:0]    pshift_q;
	logic [7:0]    pshift_d;
	logic          fwd_bit_q;
	logic          fwd_bit_d;
	logic          dout_q;
	logic          ack_q;
	logic          ack_d;
	logic          ld_push;
	logic          own_full;

	// In serial mode the first rising edge after clear counts as edge one.
	assign own_full = (ld_cnt_q == CW'(CFG_BITS));
	wire   configuration_clock_act = configuration_clock_up & clr_s;
	wire   byte_now = is_periph & configuration_clock_act &
		(started_q ? (ph_q == 3'h7) : (ph_q == 3'(`CSL_FIRST_BYTE_EDGE - 1)));
	assign ph_d     = byte_now ? 3'h0 : (ph_q + 3'h1);
	// The loaded byte's first bit leaves on the same edge, so it reaches the fall after loading.
	assign pshift_d = byte_now ? {byte_s[6:0], 1'b1} : {pshift_q[6:0], 1'b1};
	wire   par_bit  = byte_now ? byte_s[7] : pshift_q[7];
	wire   ser_bit  = is_periph ? par_bit : din_s;
	// Every bit goes downstream, this device's own included; the preamble is forwarded too.
	assign fwd_bit_d = ser_bit;
	assign ld_push   = configuration_clock_act & ~own_full & (is_serial | started_q | byte_now);
	assign ld_cnt_d  = ld_push ? (ld_cnt_q + CW'(1)) : ld_cnt_q;
	// Acknowledge stays high from one rising edge to the next.
	assign ack_d     = configuration_clock_up ? byte_now : ack_q;

	always_ff @(posedge clk) begin
		if (sys_rst | ~clr_s) begin
			ld_cnt_q  <= '0;
			ph_q      <= 3'h0;
			started_q <= 1'b0;
			pshift_q  <= 8'hFF;
			fwd_bit_q <= 1'b1;
			ack_q     <= 1'b0;
		end else begin
			if (configuration_clock_act) begin
				ph_q      <= ph_d;
				pshift_q  <= pshift_d;
				fwd_bit_q <= fwd_bit_d;
				if (byte_now)
					started_q <= 1'b1;
			end
			ld_cnt_q <= ld_cnt_d;
			ack_q    <= ack_d;
		end
	end

	// Half a period after the rising sample, the bit appears downstream.
	always_ff @(posedge clk) begin
		if (sys_rst)
			dout_q <= 1'b1;
		else if (configuration_clock_dn)
			dout_q <= fwd_bit_q;
	end
	assign daisy_serial_out = dout_q;
	assign byte_ack         = ack_q;

	// Own bits go to configuration memory through a two-entry buffer; in_ready is ignored, so a stall past two bits loses bits.
	csl_skid #(.W(1)) u_skid (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_valid  (ld_push),
		.in_ready  (),
		.in_data   (ser_bit),
		.out_valid (load_bit_valid),
		.out_ready (load_bit_ready),
		.out_data  (load_bit_data)
	);

	// Readback sequencer, stepped by rising edges of the readback shift clock.
	csl_rb_state_t st_q;
	csl_rb_state_t st_d;
	logic [FW-1:0] bit_q;
	logic [FW-1:0] frm_q;
	logic [FW-1:0] bit_d;
	logic [FW-1:0] frm_d;
	logic [15:0]   crc_q;
	logic [15:0]   crc_d;
	logic          rbout_q;
	logic          rbout_d;
	logic          rip_q;
	logic          armed_q;
	logic [AW-1:0] addr_q;

	wire           last_frame = (frm_q == FW'(FRAMES - 1));
	wire           data_end   = (bit_q == FW'(FRAME_BITS - 1));
	wire           first_hi   = (frm_q == '0) && (bit_q < FW'(`CSL_RB_FORCED_FIRST));
	wire           last_hi    = last_frame &&
		(bit_q >= FW'(FRAME_BITS - `CSL_RB_LAST_HIGH_BITS));
	// Outside the forced-high positions, state bits are live values and config bits go out as stored, never inverted.
	wire           raw_bit    = (capture_state_en & rb_state_valid) ? rb_state_bit : rb_cfg_bit;
	wire           data_bit   = (first_hi | last_hi) ? 1'b1 : raw_bit;
	wire           crc_fb     = crc_q[15] ^ rbout_d;
	wire           trig_go    = trig_s & config_done & armed_q & (st_q == CSL_RB_IDLE);

	always_comb begin
		st_d    = st_q;
		bit_d   = bit_q;
		frm_d   = frm_q;
		rbout_d = 1'b1;
		unique case (st_q)
			CSL_RB_IDLE: begin
				bit_d = '0;
				frm_d = '0;
				if (trig_go)
					st_d = CSL_RB_DUMMY;
			end
			CSL_RB_DUMMY: begin
				rbout_d = 1'b1;
				bit_d   = bit_q + FW'(1);
				// The trigger edge already sent the first dummy, so four more follow here.
				if (bit_q == FW'(`CSL_RB_DUMMY_BITS - 2)) begin
					st_d  = CSL_RB_START;
					bit_d = '0;
				end
			end
			CSL_RB_START: begin
				rbout_d = 1'b0;
				st_d    = (frm_q == FW'(FRAMES)) ? CSL_RB_SIG : CSL_RB_DATA;
			end
			CSL_RB_DATA: begin
				rbout_d = data_bit;
				bit_d   = data_end ? '0 : (bit_q + FW'(1));
				if (data_end)
					st_d = CSL_RB_CHECK;
			end
			CSL_RB_CHECK: begin
				rbout_d = 1'b1;
				bit_d   = bit_q + FW'(1);
				if (bit_q == FW'(`CSL_RB_CHECK_BITS - 1)) begin
					bit_d = '0;
					frm_d = frm_q + FW'(1);
					st_d  = CSL_RB_START;
				end
			end
			CSL_RB_SIG: begin
				// The flag falls one edge after the last signature bit, which must stand first.
				rbout_d = crc_q[15 - bit_q[3:0]];
				bit_d   = bit_q + FW'(1);
				if (bit_q == FW'(`CSL_RB_SIG_BITS)) begin
					rbout_d = 1'b1;
					st_d    = CSL_RB_IDLE;
				end
			end
		endcase
	end

	// The signature covers each frame's data and check bits, not its start bit, then freezes while it is sent.
	wire crc_run = (st_q == CSL_RB_DATA) || (st_q == CSL_RB_CHECK);
	assign crc_d = crc_run ? ({crc_q[14:0], 1'b0} ^ (crc_fb ? `CSL_CRC_POLY : 16'h0000))
		: crc_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q    <= CSL_RB_IDLE;
			bit_q   <= '0;
			frm_q   <= '0;
			crc_q   <= `CSL_CRC_INIT;
			rbout_q <= 1'b1;
			rip_q   <= 1'b0;
			armed_q <= 1'b1;
			addr_q  <= '0;
		end else begin
			if (rclk_up) begin
				st_q    <= st_d;
				bit_q   <= bit_d;
				frm_q   <= frm_d;
				rbout_q <= rbout_d;
				crc_q   <= (st_q == CSL_RB_IDLE) ? `CSL_CRC_INIT : crc_d;
				rip_q   <= (st_d != CSL_RB_IDLE);
				if (st_q == CSL_RB_DATA)
					addr_q <= addr_q + AW'(1);
				else if (st_q == CSL_RB_IDLE)
					addr_q <= '0;
			end
			// A held trigger must drop before a second readback can start.
			if (trig_go & rclk_up)
				armed_q <= 1'b0;
			else if (~trig_s & (st_q == CSL_RB_IDLE))
				armed_q <= 1'b1;
		end
	end
	// The readback path only reads memory and state; it writes nothing back.
	assign rb_addr               = addr_q;
	assign readback_serial_out   = rbout_q;
	assign read_in_progress_flag = rip_q;
endmodule

// [verif/csl_config_port_asserts.sv]
/*
 Checker for the configuration port: readback framing, flag span and loader timing.
 Assumes pin periods of at least 8 clk and readback data that reads back as zero.
*/
`timescale 1ns/1ns
module csl_port_chk #(
	parameter int FRAME_BITS = 16,
	parameter int FRAMES     = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic configuration_clock,
	input wire logic readback_shift_clock,
	input wire logic config_done,
	input wire logic daisy_serial_out,
	input wire logic byte_ack,
	input wire logic readback_serial_out,
	input wire logic read_in_progress_flag
);
	localparam int FB = FRAME_BITS + 5;
	localparam int SIG0 = 5 + FRAMES * FB;
	logic [2:0] s_q;
	logic [7:0] cnt_q;
	logic       sc_rise;
	logic       sc_fall;
	logic       fixed;
	logic       fval;
	int         frm;
	int         pos;
	assign sc_rise = s_q[1] & !s_q[2];
	assign sc_fall = !s_q[1] & s_q[2];
	assign frm = (int'(cnt_q) - 5) / FB;
	assign pos = (int'(cnt_q) - 5) % FB;
	assign fixed = int'(cnt_q) <= SIG0;
	// Free data positions read 0 because the bench feeds zero data.
	assign fval = cnt_q < 5 ? 1'b1 : int'(cnt_q) == SIG0 ? 1'b0 : pos == 0 ? 1'b0 :
		pos > FRAME_BITS ? 1'b1 : (frm == 0 && pos < 3) ? 1'b1 :
		(frm == FRAMES - 1 && pos > FRAME_BITS - 7);
	always_ff @(posedge clk) begin
		s_q <= {s_q[1:0], readback_shift_clock};
		if (sys_rst || !read_in_progress_flag)
			cnt_q <= '0;
		else if (sc_rise)
			cnt_q <= cnt_q + 8'h01;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence rb_start;
		$rose(read_in_progress_flag);
	endsequence
	sequence rb_end;
		$fell(read_in_progress_flag);
	endsequence
	chk_rip_on_shift: assert property (rb_start |-> readback_shift_clock && config_done)
		else $error("progress flag rose outside a shift edge");
	chk_first_dummy: assert property (rb_start |-> readback_serial_out)
		else $error("first readback bit not high");
	chk_bit_on_shift: assert property (read_in_progress_flag && $changed(readback_serial_out)
		|-> readback_shift_clock)
		else $error("readback bit moved without shift edge");
	chk_frame_bits: assert property (sc_fall && read_in_progress_flag && fixed
		|-> readback_serial_out == fval)
		else $error("readback framing bit wrong");
	chk_rip_length: assert property (rb_end |-> int'(cnt_q) == SIG0 + 12)
		else $error("readback flag span wrong");
	chk_no_retrigger: assert property (rb_end |-> !read_in_progress_flag [*4])
		else $error("readback restarted at once");
	chk_daisy_on_fall: assert property ($changed(daisy_serial_out) |-> !configuration_clock)
		else $error("daisy output moved while clock high");
	chk_ack_on_rise: assert property ($rose(byte_ack) |-> configuration_clock)
		else $error("acknowledge rose away from a rising edge");
	chk_ack_period: assert property ($rose(byte_ack) |-> byte_ack [*8] ##[1:4] !byte_ack)
		else $error("acknowledge width wrong");
endmodule
bind csl_config_port csl_port_chk #(.FRAME_BITS(FRAME_BITS), .FRAMES(FRAMES)) i_csl_port_chk (
	.clk, .sys_rst, .configuration_clock, .readback_shift_clock, .config_done,
	.daisy_serial_out, .byte_ack, .readback_serial_out, .read_in_progress_flag);

// [verif/csl_cfg_source.sv]
/*
 Model of the external configuration source and the next chained device.
 Assumes callers step it from the clk domain; its clock stands still between pulses.
*/
`timescale 1ns/1ns
module csl_cfg_source (
	input  wire logic       clk,
	input  wire logic       daisy_serial_out,
	output logic            configuration_clock,
	output logic            config_serial_in,
	output logic [7:0]      parallel_config_byte
);
	initial begin
		configuration_clock = 1'b0;
		config_serial_in = 1'b1;
		parallel_config_byte = 8'h00;
	end
	// Data changes after hold; the inverse stops a stale value passing as good.
	task automatic pulse(input logic d, input logic [7:0] b, output logic seen);
		config_serial_in <= d;
		parallel_config_byte <= b;
		repeat (2) @(posedge clk);
		configuration_clock <= 1'b1;
		repeat (4) @(posedge clk);
		configuration_clock <= 1'b0;
		config_serial_in <= !d;
		parallel_config_byte <= ~b;
		repeat (5) @(posedge clk);
		seen = daisy_serial_out;
	endtask
endmodule

// [verif/csl_config_port_tb.sv]
/*
 Self-checking bench for the configuration port: serial, peripheral and readback.
 Assumes the bound checker and the source model in csl_cfg_source.
*/
`timescale 1ns/1ns
module csl_config_port_tb;
	logic        clk, sys_rst, mem_clear_done, load_bit_ready, config_done;
	logic        capture_state_en, readback_trigger, readback_shift_clock;
	logic        rb_cfg_bit, rb_state_bit, rb_state_valid, ack_q;
	logic [2:0]  mode_select_pins;
	logic [7:0]  parallel_config_byte, rb_addr;
	logic        configuration_clock, config_serial_in, daisy_serial_out, byte_ack;
	logic        load_bit_valid, load_bit_data, readback_serial_out, read_in_progress_flag;
	logic [15:0] got;
	int          mismatches, comparisons, acks, ngot;
	csl_config_port i_csl_config_port (.clk, .sys_rst, .mode_select_pins, .mem_clear_done,
		.configuration_clock, .config_serial_in, .parallel_config_byte, .daisy_serial_out,
		.byte_ack, .load_bit_valid, .load_bit_ready, .load_bit_data, .config_done,
		.capture_state_en, .readback_trigger, .readback_shift_clock, .rb_addr, .rb_cfg_bit,
		.rb_state_bit, .rb_state_valid, .readback_serial_out, .read_in_progress_flag);
	csl_cfg_source i_csl_cfg_source (.clk, .daisy_serial_out, .configuration_clock,
		.config_serial_in, .parallel_config_byte);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		ack_q <= byte_ack;
		if (byte_ack && !ack_q)
			acks++;
		if (load_bit_valid && load_bit_ready && ngot < 16) begin
			got <= {got[14:0], load_bit_data};
			ngot++;
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic shift(input int n);
		repeat (n) begin
			readback_shift_clock <= 1'b1;
			repeat (4) @(posedge clk);
			readback_shift_clock <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	// The memory side stalls for two bits so the two-entry buffer fills.
	task automatic test_serial;
		logic [15:0] v;
		logic        s;
		v = 16'ha53c;
		load_bit_ready <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (i == 13)
				load_bit_ready <= 1'b1;
			i_csl_cfg_source.pulse(v[i], 8'h00, s);
			check("daisy bit", {15'h0000, s}, {15'h0000, v[i]});
		end
		check("loaded bits", got, v);
		$display("test_serial done");
	endtask
	task automatic test_periph;
		logic [7:0] b0, b1;
		logic       s;
		int         a0;
		b0 = 8'hb4;
		b1 = 8'h69;
		mode_select_pins <= 3'h3;
		mem_clear_done <= 1'b0;
		repeat (4) @(posedge clk);
		mem_clear_done <= 1'b1;
		repeat (6) @(posedge clk);
		a0 = acks;
		for (int k = 1; k <= 20; k++) begin
			i_csl_cfg_source.pulse(1'b0, k < 10 ? b0 : b1, s);
			check("ack count", 16'(acks - a0), k < 2 ? 16'h0000 : k < 10 ? 16'h0001 :
				k < 18 ? 16'h0002 : 16'h0003);
			if (k >= 2 && k <= 17)
				check("byte bit", {15'h0000, s},
					{15'h0000, k < 10 ? b0[9-k] : b1[17-k]});
		end
		$display("test_periph done");
	endtask
	task automatic test_readback;
		readback_trigger <= 1'b1;
		shift(3);
		check("flag before done", {15'h0000, read_in_progress_flag}, 16'h0000);
		config_done <= 1'b1;
		@(posedge clk);
		shift(1);
		check("flag started", {15'h0000, read_in_progress_flag}, 16'h0001);
		shift(100);
		check("flag at last bit", {15'h0000, read_in_progress_flag}, 16'h0001);
		shift(1);
		check("flag ended", {15'h0000, read_in_progress_flag}, 16'h0000);
		shift(3);
		check("no retrigger", {15'h0000, read_in_progress_flag}, 16'h0000);
		readback_trigger <= 1'b0;
		$display("test_readback done");
	endtask
	initial begin
		sys_rst = 1'b1;
		mode_select_pins = 3'h7;
		mem_clear_done = 1'b1;
		load_bit_ready = 1'b1;
		config_done = 1'b0;
		capture_state_en = 1'b0;
		readback_trigger = 1'b0;
		readback_shift_clock = 1'b0;
		rb_cfg_bit = 1'b0;
		rb_state_bit = 1'b0;
		rb_state_valid = 1'b0;
		ack_q = 1'b0;
		got = 16'h0000;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		test_serial();
		test_periph();
		test_readback();
		tally_and_finish();
	end
	initial begin
		#160000;
		mismatches++;
		tally_and_finish();
	end
endmodule
